// ===== ipe_pkg.sv
// Purpose: Shared constants and types for the infrared pulse encoder/decoder.
// Assumes: One baud tick per sixteenth of a bit, supplied by the UART.
// Notes: Counts are in baud ticks unless the name says otherwise.
package ipe_pkg;

  // Bit period: sixteen ticks, counted 0 to 15.
  localparam int unsigned CNT_W = 4;
  localparam logic [3:0] BIT_LAST = 4'hf;
  // Transmit pulse for a zero: low 0..6, high 7..9, low 10..15.
  localparam logic [3:0] PULSE_FIRST = 4'h7;
  localparam logic [3:0] PULSE_LAST = 4'h9;
  // Receive timing relative to the last detected falling edge.
  localparam logic [3:0] RX_UPDATE = 4'h8;
  localparam logic [3:0] RX_WIN_OPEN = 4'hc;
  // Bit periods without a pulse before the decoder falls idle.
  localparam logic [3:0] RX_IDLE_MISS = 4'ha;
  // Ticks that the receiver stays deaf after transmit activity.
  localparam logic [4:0] TX_HOLD_TICKS = 5'h10;
  // Idle level of the UART serial lines.
  localparam logic LINE_IDLE = 1'b1;
  // Width of one entry of the decoded bit buffer.
  localparam int unsigned BUF_W = 1;

  // Supported infrared bit rates and the receive clock floor.
  localparam int unsigned IR_BAUD_MIN = 9600;
  localparam int unsigned IR_BAUD_MAX = 115200;
  localparam int unsigned SYSCLK_MIN_HZ = 1000000;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned IR_PULSE_MIN_NS = 1400;
  localparam int unsigned IR_PULSE_MIN_CYC = IR_PULSE_MIN_NS / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    RX_IDLE = 3'b001,
    RX_HOLD = 3'b010,
    RX_WINDOW = 3'b100
  } ipe_rx_state_t;

endpackage

// ===== ipe_buf2.sv
// Purpose: Two-entry buffer with valid and ready on both sides.
// Assumes: Push and pop may happen in the same cycle.
// Notes: All state holds while clk_en is low.
`timescale 1ns/1ps
module ipe_buf2
  import ipe_pkg::*;
#(
  parameter int unsigned W = BUF_W
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic reset,
  input wire logic clk_en,
  // Filling side.
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // Draining side.
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);

  logic [W-1:0] mem_ff [2];
  logic wr_ptr_ff;
  logic rd_ptr_ff;
  logic [1:0] cnt_ff;
  logic push;
  logic pop;

  assign in_ready = cnt_ff != 2'h2;
  assign out_valid = cnt_ff != 2'h0;
  assign out_data = mem_ff[rd_ptr_ff];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Storage is not reset; the count guards every read.
  always_ff @(posedge core_clk) begin
    if (clk_en && push) begin
      mem_ff[wr_ptr_ff] <= in_data;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      wr_ptr_ff <= 1'b0;
      rd_ptr_ff <= 1'b0;
      cnt_ff <= 2'h0;
    end else if (clk_en) begin
      if (push) begin
        wr_ptr_ff <= ~wr_ptr_ff;
      end
      if (pop) begin
        rd_ptr_ff <= ~rd_ptr_ff;
      end
      case ({push, pop})
        2'b10: cnt_ff <= cnt_ff + 2'h1;
        2'b01: cnt_ff <= cnt_ff - 2'h1;
        default: cnt_ff <= cnt_ff;
      endcase
    end
  end

endmodule

// ===== ipe_endec.sv
// Purpose: Infrared pulse encoder/decoder between a UART and a transceiver.
// Assumes: Pins and baud tick are synchronous to core_clk.
// Notes: Decoded bits also leave through a two-entry buffer.
// Contract
// - Encoder uses UART transmit bit and tick.
// - Each bit lasts sixteen baud ticks.
// - One bit keeps infrared output low.
// - Zero bit: low seven, high three, low six.
// - Enabled: pulse output drives transmit pin.
// - Enabled: decoded stream feeds UART receive.
// - Never transmit and receive together.
// - Bit rate is clock over sixteen divisor.
// - Supports 9600 to 115.2 kbaud rates.
// - Receive tick counter runs zero to fifteen.
// - Decoded stream lags input by eight ticks.
// - Falling input edge resets receive counter.
// - At count eight, update UART receive.
// - Window opens at twelve, closes at eight.
`timescale 1ns/1ps
module ipe_endec
  import ipe_pkg::*;
(
  // Clock, reset and freeze.
  input wire logic core_clk,
  input wire logic reset,
  input wire logic clk_en,
  // Mode and UART timing.
  input wire logic endec_en,
  input wire logic baud_tick,
  // UART side.
  input wire logic uart_txd,
  output logic uart_rxd,
  // Decoded bit stream.
  output logic rx_bit_data,
  output logic rx_bit_valid,
  input wire logic rx_bit_ready,
  // Pins.
  output logic txd_pin,
  input wire logic rxd_pin
);

  logic adv;
  logic infrared_rx_pulse_in;
  logic infrared_tx_pulse_out_ff;
  logic txd_pin_ff;
  logic uart_rxd_ff;
  logic [3:0] tx_cnt_ff;
  logic tx_bit_ff;
  logic [4:0] tx_hold_ff;
  logic tx_busy;
  logic tx_start;
  logic rx_prev_ff;
  logic rx_fall;
  logic rx_take;
  logic rx_update;
  logic [3:0] rx_cnt_ff;
  logic [3:0] nxt_rx_cnt;
  logic [3:0] rx_miss_ff;
  logic rx_pulse_seen_ff;
  ipe_rx_state_t rx_state_ff;
  ipe_rx_state_t nxt_rx_state;
  logic pend_valid_ff;
  logic pend_data_ff;
  logic buf_in_ready;

  // Each UART baud tick is one sixteenth of a bit.
  assign adv = clk_en && baud_tick;
  assign infrared_rx_pulse_in = rxd_pin;
  assign txd_pin = txd_pin_ff;
  assign uart_rxd = uart_rxd_ff;

  // Transmit is busy while the UART line or the current bit shows activity.
  assign tx_busy = tx_hold_ff != 5'h0;
  assign tx_start = endec_en && !tx_busy && !uart_txd;

  // Bit phase follows the UART start bit and the baud tick only.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      tx_cnt_ff <= 4'h0;
      tx_bit_ff <= LINE_IDLE;
    end else if (adv) begin
      if (!endec_en) begin
        tx_cnt_ff <= 4'h0;
        tx_bit_ff <= LINE_IDLE;
      end else if (tx_start) begin
        tx_cnt_ff <= 4'h0;
        tx_bit_ff <= 1'b0;
      end else begin
        tx_cnt_ff <= tx_cnt_ff + 4'h1;
        if (tx_cnt_ff == BIT_LAST) begin
          tx_bit_ff <= uart_txd;
        end
      end
    end
  end

  // Activity hold that keeps the receiver deaf during transmit.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      tx_hold_ff <= 5'h0;
    end else if (adv) begin
      if (endec_en && (!uart_txd || !tx_bit_ff)) begin
        tx_hold_ff <= TX_HOLD_TICKS;
      end else if (tx_busy) begin
        tx_hold_ff <= tx_hold_ff - 5'h1;
      end
    end
  end

  // A zero bit pulses in ticks 7..9, a one bit stays low.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      infrared_tx_pulse_out_ff <= 1'b0;
    end else if (clk_en) begin
      infrared_tx_pulse_out_ff <= endec_en && !tx_bit_ff &&
        (tx_cnt_ff >= PULSE_FIRST) && (tx_cnt_ff <= PULSE_LAST);
    end
  end

  // Pin mux: pulses when enabled, raw UART line otherwise.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      txd_pin_ff <= LINE_IDLE;
    end else if (clk_en) begin
      txd_pin_ff <= endec_en ? infrared_tx_pulse_out_ff : uart_txd;
    end
  end

  // Falling edge of the infrared input, accepted only in idle or window.
  assign rx_fall = rx_prev_ff && !infrared_rx_pulse_in;
  assign rx_take = clk_en && endec_en && !tx_busy && rx_fall &&
    (rx_state_ff == RX_IDLE || rx_state_ff == RX_WINDOW);

  always_ff @(posedge core_clk) begin
    if (reset) begin
      rx_prev_ff <= LINE_IDLE;
    end else if (clk_en) begin
      rx_prev_ff <= infrared_rx_pulse_in;
    end
  end

  // Local tick counter, cleared by an accepted edge.
  always_comb begin
    nxt_rx_cnt = rx_cnt_ff;
    if (rx_take) begin
      nxt_rx_cnt = 4'h0;
    end else if (adv) begin
      nxt_rx_cnt = rx_cnt_ff + 4'h1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      rx_cnt_ff <= 4'h0;
    end else if (clk_en) begin
      rx_cnt_ff <= nxt_rx_cnt;
    end
  end

  // Decision point eight ticks after the pulse edge.
  assign rx_update = adv && !rx_take && (nxt_rx_cnt == RX_UPDATE) &&
    (rx_state_ff != RX_IDLE);

  always_comb begin
    nxt_rx_state = rx_state_ff;
    unique case (rx_state_ff)
      RX_IDLE: begin
        if (rx_take) begin
          nxt_rx_state = RX_HOLD;
        end
      end
      RX_HOLD: begin
        if (rx_cnt_ff == RX_WIN_OPEN) begin
          nxt_rx_state = RX_WINDOW;
        end
      end
      RX_WINDOW: begin
        if (rx_take) begin
          nxt_rx_state = RX_HOLD;
        end else if (rx_update) begin
          nxt_rx_state = (rx_miss_ff == RX_IDLE_MISS - 4'h1) ? RX_IDLE : RX_HOLD;
        end
      end
    endcase
    if (!endec_en || tx_busy) begin
      nxt_rx_state = RX_IDLE;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      rx_state_ff <= RX_IDLE;
    end else if (clk_en) begin
      rx_state_ff <= nxt_rx_state;
    end
  end

  // Pulse flag for the current bit; an edge sets, a decision clears.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      rx_pulse_seen_ff <= 1'b0;
      rx_miss_ff <= 4'h0;
    end else if (clk_en) begin
      if (rx_take) begin
        rx_pulse_seen_ff <= 1'b1;
        rx_miss_ff <= 4'h0;
      end else if (rx_update) begin
        rx_pulse_seen_ff <= 1'b0;
        if (!rx_pulse_seen_ff) begin
          rx_miss_ff <= rx_miss_ff + 4'h1;
        end
      end else if (nxt_rx_state == RX_IDLE) begin
        rx_pulse_seen_ff <= 1'b0;
        rx_miss_ff <= 4'h0;
      end
    end
  end

  // UART receive line: decoded when enabled, raw pin when not.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      uart_rxd_ff <= LINE_IDLE;
    end else if (clk_en) begin
      if (!endec_en) begin
        uart_rxd_ff <= infrared_rx_pulse_in;
      end else if (tx_busy) begin
        uart_rxd_ff <= LINE_IDLE;
      end else if (rx_update) begin
        uart_rxd_ff <= !rx_pulse_seen_ff;
      end
    end
  end

  // Decoded bit waits here until the buffer has room.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      pend_valid_ff <= 1'b0;
      pend_data_ff <= LINE_IDLE;
    end else if (clk_en) begin
      if (rx_update) begin
        pend_valid_ff <= 1'b1;
        pend_data_ff <= !rx_pulse_seen_ff;
      end else if (buf_in_ready) begin
        pend_valid_ff <= 1'b0;
      end
    end
  end

  ipe_buf2 #(
    .W(BUF_W)
  ) i_ipe_buf2 (
    .core_clk(core_clk),
    .reset(reset),
    .clk_en(clk_en),
    .in_valid(pend_valid_ff),
    .in_ready(buf_in_ready),
    .in_data(pend_data_ff),
    .out_valid(rx_bit_valid),
    .out_ready(rx_bit_ready),
    .out_data(rx_bit_data)
  );

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);

  property p_tx_one_quiet;
    $past(clk_en) && $past(tx_bit_ff) |-> !infrared_tx_pulse_out_ff;
  endproperty
  a_tx_one_quiet: assert property (p_tx_one_quiet)
    else $error("Pulse sent during a one bit.");

  property p_tx_zero_pulse;
    $rose(infrared_tx_pulse_out_ff) |->
      $past(tx_cnt_ff) == PULSE_FIRST && !$past(tx_bit_ff);
  endproperty
  a_tx_zero_pulse: assert property (p_tx_zero_pulse)
    else $error("Pulse started at the wrong tick.");

  property p_bit_wrap;
    adv && endec_en && !tx_start && tx_cnt_ff == BIT_LAST |=> tx_cnt_ff == 4'h0;
  endproperty
  a_bit_wrap: assert property (p_bit_wrap)
    else $error("Bit period is not sixteen ticks.");

  property p_pin_pulse;
    $past(clk_en) && $past(endec_en) |-> txd_pin_ff == $past(infrared_tx_pulse_out_ff);
  endproperty
  a_pin_pulse: assert property (p_pin_pulse)
    else $error("Transmit pin does not carry the pulse output.");

  property p_pin_bypass;
    $past(clk_en) && !$past(endec_en) |-> txd_pin_ff == $past(uart_txd);
  endproperty
  a_pin_bypass: assert property (p_pin_bypass)
    else $error("Transmit pin does not follow the UART when disabled.");

  property p_half_duplex;
    clk_en && tx_busy |=> rx_state_ff == RX_IDLE && !rx_pulse_seen_ff;
  endproperty
  a_half_duplex: assert property (p_half_duplex)
    else $error("Receiver active while transmitting.");

  property p_edge_reset;
    rx_take |=> rx_cnt_ff == 4'h0 ##1 rx_pulse_seen_ff;
  endproperty
  a_edge_reset: assert property (p_edge_reset)
    else $error("Falling edge did not clear the counter.");

  property p_update_at8;
    endec_en && $past(endec_en) && !$past(tx_busy) && $changed(uart_rxd_ff)
      |-> rx_cnt_ff == RX_UPDATE;
  endproperty
  a_update_at8: assert property (p_update_at8)
    else $error("Receive output changed away from count eight.");

  property p_window_open;
    $rose(rx_state_ff == RX_WINDOW) |-> $past(rx_cnt_ff) == RX_WIN_OPEN;
  endproperty
  a_window_open: assert property (p_window_open)
    else $error("Sampling window opened at the wrong count.");

  property p_decode_zero;
    endec_en && !tx_busy && rx_update && rx_pulse_seen_ff |=> !uart_rxd_ff && pend_valid_ff;
  endproperty
  a_decode_zero: assert property (p_decode_zero)
    else $error("Detected pulse did not decode as zero.");

  c_zero_sent: cover property ($rose(infrared_tx_pulse_out_ff));
  c_zero_decoded: cover property (rx_update && rx_pulse_seen_ff);
  c_buffer_full: cover property (pend_valid_ff && !buf_in_ready);

endmodule

// ===== ipe_xcvr_model.sv
// Purpose: Behavioural model of the infrared transceiver on the serial pins.
// Assumes: Receive light pulses reach the block as low-going levels, idle high.
// Notes: Keeps a baud tick count and records every transmit pulse it sees.
`timescale 1ns/1ps
module ipe_xcvr_model (
  // Clock and UART tick.
  input wire logic core_clk,
  input wire logic baud_tick,
  // Optical side.
  input wire logic txd_pin,
  output logic rxd_pin
);
  int tick_n = 0;
  int hi_cyc = 0;
  int rise_q[$];
  logic prev_tx = 1'b1;

  initial begin
    rxd_pin = 1'b1;
  end

  // Counts ticks, high cycles and the tick at which each pulse starts.
  always @(posedge core_clk) begin
    if (baud_tick) begin
      tick_n <= tick_n + 1;
    end
    if (txd_pin) begin
      hi_cyc <= hi_cyc + 1;
    end
    if (txd_pin && !prev_tx) begin
      rise_q.push_back(tick_n);
    end
    prev_tx <= txd_pin;
  end

  // Sends one symbol; a zero is a low pulse over ticks 7 to 9, else idle high.
  task automatic send_bit(input logic b);
    for (int k = 0; k < 16; k++) begin
      @(posedge core_clk iff baud_tick);
      rxd_pin <= b | (k < 7) | (k > 9);
    end
  endtask
endmodule

// ===== ipe_endec_tb.sv
// Purpose: Self-checking bench for the infrared pulse encoder/decoder.
// Assumes: One baud tick every four clocks, made here in place of the UART.
// Notes: Each scenario is a task that judges the block; all but test_reset also drive it.
`timescale 1ns/1ps
module ipe_endec_tb;
  import ipe_pkg::*;
  localparam int TICK_DIV = 4;
  logic core_clk;
  logic reset;
  logic clk_en;
  logic endec_en;
  logic baud_tick;
  logic uart_txd;
  logic rx_bit_ready;
  logic uart_rxd;
  logic rx_bit_data;
  logic rx_bit_valid;
  logic txd_pin;
  logic rxd_pin;
  logic [1:0] div_q = 2'h0;
  logic rxd_q = 1'b1;
  logic urx_q = 1'b1;
  logic urx_low = 1'b0;
  logic got[$];
  int fall_q[$];
  int ufall_q[$];
  int num_errors = 0;
  int n_compared = 0;

  // A 100 MHz clock sits well above the receive floor.
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // The UART runs first and ticks every four clocks.
  always @(posedge core_clk) begin
    div_q <= div_q + 2'h1;
    baud_tick <= (div_q == 2'h3);
  end

  ipe_endec i_ipe_endec (
    .core_clk(core_clk), .reset(reset), .clk_en(clk_en), .endec_en(endec_en),
    .baud_tick(baud_tick), .uart_txd(uart_txd), .uart_rxd(uart_rxd),
    .rx_bit_data(rx_bit_data), .rx_bit_valid(rx_bit_valid),
    .rx_bit_ready(rx_bit_ready), .txd_pin(txd_pin), .rxd_pin(rxd_pin)
  );

  ipe_xcvr_model i_ipe_xcvr_model (
    .core_clk(core_clk), .baud_tick(baud_tick), .txd_pin(txd_pin), .rxd_pin(rxd_pin)
  );

  // Records falling edges and every word taken from the stream.
  always @(posedge core_clk) begin
    if (!rxd_pin && rxd_q) begin
      fall_q.push_back(i_ipe_xcvr_model.tick_n);
    end
    if (!uart_rxd && urx_q) begin
      ufall_q.push_back(i_ipe_xcvr_model.tick_n);
    end
    if (!uart_rxd) begin
      urx_low = 1'b1;
    end
    if (rx_bit_valid && rx_bit_ready) begin
      got.push_back(rx_bit_data);
    end
    rxd_q <= rxd_pin;
    urx_q <= uart_rxd;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic wait_ticks(input int n);
    repeat (n) @(posedge core_clk iff baud_tick);
  endtask

  task automatic test_reset();
    @(posedge core_clk);
    #1;
    chk("txd_pin", 1'b1, txd_pin);
    chk("uart_rxd", 1'b1, uart_rxd);
    chk("rx_bit_valid", 1'b0, rx_bit_valid);
    $display("test reset done");
  endtask

  task automatic test_freeze();
    @(posedge core_clk);
    clk_en <= 1'b0;
    uart_txd <= 1'b0;
    repeat (4) @(posedge core_clk);
    #1 chk("txd_pin frozen", 1'b1, txd_pin);
    @(posedge core_clk);
    clk_en <= 1'b1;
    repeat (2) @(posedge core_clk);
    #1 chk("txd_pin released", 1'b0, txd_pin);
    @(posedge core_clk);
    uart_txd <= 1'b1;
    repeat (2) @(posedge core_clk);
    #1 chk("txd_pin back", 1'b1, txd_pin);
    $display("test freeze done");
  endtask

  task automatic test_passthru();
    @(posedge core_clk);
    uart_txd <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1 chk("txd_pin", 1'b0, txd_pin);
    @(posedge core_clk);
    uart_txd <= 1'b1;
    repeat (2) @(posedge core_clk);
    #1 chk("txd_pin", 1'b1, txd_pin);
    urx_low = 1'b0;
    i_ipe_xcvr_model.send_bit(1'b0);
    #1 chk("uart_rxd low", 1'b1, urx_low);
    $display("test passthru done");
  endtask

  task automatic test_tx();
    int s;
    int h0;
    int r0;
    @(posedge core_clk);
    endec_en <= 1'b1;
    wait_ticks(4);
    #1 chk("txd_pin idle", 1'b0, txd_pin);
    h0 = i_ipe_xcvr_model.hi_cyc;
    r0 = i_ipe_xcvr_model.rise_q.size();
    urx_low = 1'b0;
    @(posedge core_clk iff baud_tick);
    uart_txd <= 1'b0;
    s = i_ipe_xcvr_model.tick_n;
    fork
      i_ipe_xcvr_model.send_bit(1'b0);
    join_none
    wait_ticks(24);
    uart_txd <= 1'b1;
    wait_ticks(40);
    #1;
    chk("pulses", 2, i_ipe_xcvr_model.rise_q.size() - r0);
    chk("rise", 2 + PULSE_FIRST, i_ipe_xcvr_model.rise_q[r0] - s);
    chk("period", 16, i_ipe_xcvr_model.rise_q[r0 + 1] - i_ipe_xcvr_model.rise_q[r0]);
    chk("high", 2 * 3 * TICK_DIV, i_ipe_xcvr_model.hi_cyc - h0);
    chk("rx during tx", 1'b0, urx_low);
    $display("test tx done");
  endtask

  task automatic test_rx();
    int f0;
    int u0;
    wait_ticks(24);
    got.delete();
    f0 = fall_q.size();
    u0 = ufall_q.size();
    i_ipe_xcvr_model.send_bit(1'b0);
    i_ipe_xcvr_model.send_bit(1'b1);
    i_ipe_xcvr_model.send_bit(1'b0);
    wait_ticks(20);
    #1;
    chk("lag", RX_UPDATE, ufall_q[u0] - fall_q[f0]);
    chk("bit0", 1'b0, got[0]);
    chk("bit1", 1'b1, got[1]);
    chk("bit2", 1'b0, got[2]);
    $display("test rx done");
  endtask

  task automatic test_stall();
    wait_ticks(192);
    rx_bit_ready <= 1'b0;
    #1 got.delete();
    i_ipe_xcvr_model.send_bit(1'b0);
    i_ipe_xcvr_model.send_bit(1'b0);
    wait_ticks(24);
    #1;
    chk("valid held", 1'b1, rx_bit_valid);
    chk("no pops", 0, got.size());
    @(posedge core_clk);
    rx_bit_ready <= 1'b1;
    wait_ticks(2);
    #1;
    chk("head0", 1'b0, got[0]);
    chk("head1", 1'b0, got[1]);
    $display("test stall done");
  endtask

  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    reset = 1'b1;
    clk_en = 1'b1;
    endec_en = 1'b0;
    uart_txd = LINE_IDLE;
    rx_bit_ready = 1'b1;
    repeat (3) @(posedge core_clk);
    reset <= 1'b0;
    test_reset();
    test_passthru();
    test_freeze();
    test_tx();
    test_rx();
    test_stall();
    report_and_stop();
  end

  // The tests need some 2000 clocks; ten times that means a hang.
  initial begin
    repeat (20000) @(posedge core_clk);
    num_errors++;
    report_and_stop();
  end
endmodule
